// ### design/alu_datapath_consts.vh
`ifndef ALU_DATAPATH_CONSTS_VH
`define ALU_DATAPATH_CONSTS_VH

// register byte offsets on the apb bus
`define OFS_SRC_A 8'h00
`define OFS_SRC_B 8'h04
`define OFS_IMM 8'h08
`define OFS_SHAMT 8'h0C
`define OFS_CTRL 8'h10
`define OFS_RESULT 8'h14
`define OFS_FLAGS 8'h18
`define OFS_BRANCH 8'h1C

// control register fields
`define CTRL_OP_MSB 3
`define CTRL_OP_LSB 0
`define CTRL_SET_FLAGS 4
`define CTRL_USE_IMM 5
`define CTRL_SHAMT_REG 6
`define CTRL_PC_BASE 7
`define CTRL_PC_WRITE 8
`define CTRL_DEST_GIVEN 9
`define CTRL_O2_KIND_MSB 14
`define CTRL_O2_KIND_LSB 12
`define CTRL_O2_AMT_MSB 20
`define CTRL_O2_AMT_LSB 16
`define CTRL_USED_MASK 32'h001F_73FF

// flags register bit positions
`define FLAG_N 3
`define FLAG_Z 2
`define FLAG_C 1
`define FLAG_V 0

// immediate field widths
`define TWELVE_BIT_IMMEDIATE_MASK 32'h0000_0FFF
`define IMM_SHIFT_MSB 5

// operation codes
`define OP_SUM 4'h0
`define OP_SUM_CARRY 4'h1
`define OP_DIFF 4'h2
`define OP_DIFF_BORROW 4'h3
`define OP_REV_DIFF 4'h4
`define OP_CONJ 4'h5
`define OP_DISJ 4'h6
`define OP_XOR 4'h7
`define OP_CLEAR_BITS 4'h8
`define OP_OR_INV 4'h9
`define OP_ASR 4'hA
`define OP_LSL 4'hB
`define OP_LSR 4'hC
`define OP_ROR 4'hD
`define OP_RRX 4'hE
`define OP_CLZ 4'hF

// shifter kinds
`define SH_LSL 3'h0
`define SH_LSR 3'h1
`define SH_ASR 3'h2
`define SH_ROR 3'h3
`define SH_RRX 3'h4

// reset values, word width, clz all-zero count and pc masks
`define RST_WORD 32'h0000_0000
`define RST_FLAGS 4'h0
`define WORD_BITS 32
`define CLZ_ALL_ZERO 6'h20
`define PC_ALIGN_MASK 32'hFFFF_FFFC
`define PC_BIT0_MASK 32'hFFFF_FFFE

`endif

// ### design/integer_alu_shift_datapath.v
// Notes on behaviour
// RQ1 - sum adds flexible operand or 12-bit immediate
// RQ2 - sum with carry adds carry flag too
// RQ3 - difference subtracts operand or 12-bit immediate
// RQ4 - borrow form subtracts one more when carry clear
// RQ5 - reversed difference is operand minus first source
// RQ6 - no destination given: result overwrites first source
// RQ7 - flags change only with flag-update bit set
// RQ8 - arithmetic with flag update sets N Z C V
// RQ9 - pc base has low two bits cleared
// RQ10 - pc write branches with result bit 0 cleared
// RQ11 - pc base only unflagged sum/diff, constant 0-4095; code aligns the base for every op, flagged or not
// RQ12 - wide immediate forms equal twelve-bit immediate forms
// RQ13 - conjunction, xor, disjunction act bit by bit
// RQ14 - clear bits ands with complemented operand
// RQ15 - or inverted ors with complemented operand
// RQ16 - logical flags: N Z, shifter carry, V kept
// RQ17 - register shift amount uses low byte only
// RQ18 - immediate shift 1-32 right, 0-31 left/rotate
// RQ19 - rotate through carry moves right by one
// RQ20 - shifts write destination, shift source unchanged
// RQ21 - shift carry is last bit out, kept at zero
// RQ22 - stack pointer destination only in sp sum/diff
// RQ23 - leading zero count: 32 for zero, 0 if msb
// RQ24 - arithmetic right fills sign, logical fills zero
// RQ25 - rotate through carry: carry in msb, bit0 out
`timescale 1ns/1ps
`include "alu_datapath_consts.vh"
`default_nettype none

module integer_alu_shift_datapath #(
   parameter AW = 8
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg [31:0] alu_result,
   output reg [3:0] flags_nzcv,
   output reg branch_valid,
   output reg [31:0] branch_addr
);

   // returns {carry_out, result}; amount zero keeps the incoming carry except for rrx, which always moves bit 0 out
   function [32:0] shifter;
      input [2:0] kind;
      input [31:0] v;
      input [7:0] amt;
      input cin;
      reg [32:0] t;
      reg [63:0] w;
      reg signed [32:0] s;
      begin
         t = {cin, v};
         w = {v, v};
         s = 33'sd0;
         case (kind)
            `SH_LSL: begin
               // past the word width everything, carry too, is shifted out
               if (amt > 8'd32)
                  t = 33'd0;
               else if (amt != 8'd0)
                  t = {1'b0, v} << amt[5:0];
            end
            `SH_LSR: begin
               if (amt > 8'd32) begin
                  t = 33'd0;
               end else if (amt != 8'd0) begin
                  w = {v, 32'h0000_0000} >> amt[5:0];
                  t = {w[31], w[63:32]}; // RQ24
               end
            end
            `SH_ASR: begin
               if (amt >= 8'd32) begin
                  t = {v[31], {32{v[31]}}}; // RQ24
               end else if (amt != 8'd0) begin
                  s = $signed({v, 1'b0}) >>> amt[4:0]; // RQ24
                  t = {s[0], s[32:1]};
               end
            end
            `SH_ROR: begin
               if (amt != 8'd0) begin
                  w = {v, v} >> amt[4:0];
                  t = {w[31], w[31:0]};
               end
            end
            `SH_RRX: t = {v[0], cin, v[31:1]}; // RQ19 RQ25
            default: t = {cin, v};
         endcase
         shifter = t;
      end
   endfunction

   // returns {carry_out, overflow, sum}
   function [33:0] adder;
      input [31:0] a;
      input [31:0] b;
      input cin;
      reg [32:0] s;
      begin
         s = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
         adder = {s[32], (a[31] == b[31]) && (s[31] != a[31]), s[31:0]};
      end
   endfunction

   function [5:0] lead_zeros;
      input [31:0] v;
      integer i;
      reg found;
      begin
         lead_zeros = `CLZ_ALL_ZERO;
         found = 1'b0;
         for (i = `WORD_BITS - 1; i >= 0; i = i - 1) begin
            if (!found && v[i]) begin
               lead_zeros = 6'd31 - i[5:0];
               found = 1'b1;
            end
         end
      end
   endfunction

   function mapped;
      input [AW-1:0] a;
      begin
         case (a[7:0])
            `OFS_SRC_A, `OFS_SRC_B, `OFS_IMM, `OFS_SHAMT,
            `OFS_CTRL, `OFS_RESULT, `OFS_FLAGS, `OFS_BRANCH: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   endfunction

   reg [31:0] src_a_reg;
   reg [31:0] src_b_reg;
   reg [31:0] imm_reg;
   reg [31:0] shamt_reg;
   reg [31:0] ctrl_reg;

   wire setup = psel & ~penable;
   wire wr_en = psel & penable & pready & pwrite & mapped(paddr);
   wire exec = wr_en && (paddr[7:0] == `OFS_CTRL);

   // control fields come straight from the write data so the result is
   // committed on the same edge as the write and any later read sees it
   wire [3:0] op = pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
   wire set_flags = pwdata[`CTRL_SET_FLAGS];
   wire use_imm = pwdata[`CTRL_USE_IMM];
   wire shamt_from_reg = pwdata[`CTRL_SHAMT_REG];
   wire pc_base = pwdata[`CTRL_PC_BASE];
   wire pc_write = pwdata[`CTRL_PC_WRITE];
   wire dest_given = pwdata[`CTRL_DEST_GIVEN];
   wire [2:0] o2_kind = pwdata[`CTRL_O2_KIND_MSB:`CTRL_O2_KIND_LSB];
   wire [4:0] o2_amt = pwdata[`CTRL_O2_AMT_MSB:`CTRL_O2_AMT_LSB];

   // carry in is the committed flag, so chained carry ops see the last result
   wire cin = flags_nzcv[`FLAG_C];

   reg [31:0] base;
   reg [32:0] op2_sh;
   reg [31:0] op2;
   reg op2_c;
   reg [7:0] sh_amt;
   reg [32:0] sh_out;
   reg [33:0] ar;
   reg [31:0] res;
   reg [3:0] flags_new;
   reg is_arith;
   reg is_logic;
   reg is_shift;

   always @* begin
      // RQ9: pc-relative base is word aligned
      base = pc_base ? (src_a_reg & `PC_ALIGN_MASK) : src_a_reg; // RQ9
      op2_sh = shifter(o2_kind, src_b_reg, {3'b000, o2_amt}, cin);
      // RQ1 RQ3 RQ12: immediate path is zero-extended 12 bits, unshifted
      op2 = use_imm ? (imm_reg & `TWELVE_BIT_IMMEDIATE_MASK) : op2_sh[31:0]; // RQ1 RQ12
      op2_c = use_imm ? cin : op2_sh[32];
      // RQ17 RQ18: register amount is its low byte, else the short field
      sh_amt = shamt_from_reg ? shamt_reg[7:0] // RQ17
                              : {2'b00, imm_reg[`IMM_SHIFT_MSB:0]}; // RQ18
      sh_out = 33'd0;
      ar = 34'd0;
      res = 32'h0000_0000;
      is_arith = 1'b0;
      is_logic = 1'b0;
      is_shift = 1'b0;
      case (op)
         `OP_SUM: begin
            ar = adder(base, op2, 1'b0); // RQ1
            is_arith = 1'b1;
         end
         `OP_SUM_CARRY: begin
            ar = adder(base, op2, cin); // RQ2
            is_arith = 1'b1;
         end
         `OP_DIFF: begin
            ar = adder(base, ~op2, 1'b1); // RQ3
            is_arith = 1'b1;
         end
         `OP_DIFF_BORROW: begin
            ar = adder(base, ~op2, cin); // RQ4
            is_arith = 1'b1;
         end
         `OP_REV_DIFF: begin
            ar = adder(op2, ~base, 1'b1); // RQ5
            is_arith = 1'b1;
         end
         `OP_CONJ: begin
            res = base & op2; // RQ13
            is_logic = 1'b1;
         end
         `OP_DISJ: begin
            res = base | op2; // RQ13
            is_logic = 1'b1;
         end
         `OP_XOR: begin
            res = base ^ op2; // RQ13
            is_logic = 1'b1;
         end
         `OP_CLEAR_BITS: begin
            res = base & ~op2; // RQ14
            is_logic = 1'b1;
         end
         `OP_OR_INV: begin
            res = base | ~op2; // RQ15
            is_logic = 1'b1;
         end
         `OP_ASR: begin
            sh_out = shifter(`SH_ASR, src_b_reg, sh_amt, cin); // RQ24
            is_shift = 1'b1;
         end
         `OP_LSL: begin
            sh_out = shifter(`SH_LSL, src_b_reg, sh_amt, cin);
            is_shift = 1'b1;
         end
         `OP_LSR: begin
            sh_out = shifter(`SH_LSR, src_b_reg, sh_amt, cin); // RQ24
            is_shift = 1'b1;
         end
         `OP_ROR: begin
            sh_out = shifter(`SH_ROR, src_b_reg, sh_amt, cin);
            is_shift = 1'b1;
         end
         `OP_RRX: begin
            sh_out = shifter(`SH_RRX, src_b_reg, 8'd1, cin); // RQ19
            is_shift = 1'b1;
         end
         `OP_CLZ: res = {26'h000_0000, lead_zeros(src_b_reg)}; // RQ23
         default: res = 32'h0000_0000;
      endcase
      if (is_arith)
         res = ar[31:0];
      else if (is_shift)
         res = sh_out[31:0];
      flags_new = flags_nzcv;
      if (set_flags && !pc_write && op != `OP_CLZ) begin // RQ7
         flags_new[`FLAG_N] = res[31];
         flags_new[`FLAG_Z] = (res == 32'h0000_0000);
         if (is_arith) begin
            flags_new[`FLAG_C] = ar[33]; // RQ8
            flags_new[`FLAG_V] = ar[32]; // RQ8
         end else if (is_logic) begin
            flags_new[`FLAG_C] = op2_c; // RQ16
         end else begin
            // zero length keeps the old carry inside the shifter
            flags_new[`FLAG_C] = sh_out[32]; // RQ21 RQ25
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_a_reg <= `RST_WORD;
         src_b_reg <= `RST_WORD;
         imm_reg <= `RST_WORD;
         shamt_reg <= `RST_WORD;
         ctrl_reg <= `RST_WORD;
         alu_result <= `RST_WORD;
         flags_nzcv <= `RST_FLAGS;
         branch_valid <= 1'b0;
         branch_addr <= `RST_WORD;
      end else begin
         branch_valid <= 1'b0;
         if (wr_en) begin
            case (paddr[7:0])
               // writes to result or branch fall to default and are dropped
               `OFS_SRC_A: begin
                  src_a_reg <= pwdata;
               end
               `OFS_SRC_B: begin
                  src_b_reg <= pwdata;
               end
               `OFS_IMM: begin
                  imm_reg <= pwdata;
               end
               `OFS_SHAMT: begin
                  shamt_reg <= pwdata;
               end
               `OFS_FLAGS: begin
                  flags_nzcv <= pwdata[3:0];
               end
               default: ;
            endcase
         end
         if (exec) begin
            ctrl_reg <= pwdata & `CTRL_USED_MASK;
            // RQ20: shift source register is never written here
            alu_result <= res; // RQ20
            flags_nzcv <= flags_new; // RQ7
            if ((is_arith || is_logic) && !dest_given)
               src_a_reg <= res; // RQ6
            if (pc_write && op == `OP_SUM) begin
               branch_addr <= res & `PC_BIT0_MASK; // RQ10
               branch_valid <= 1'b1; // RQ10
            end
         end
      end
   end

   // zero wait state: ready is raised for the access cycle only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `RST_WORD;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped(paddr);
         prdata <= `RST_WORD;
         if (setup && !pwrite) begin
            case (paddr[7:0])
               `OFS_SRC_A: begin
                  prdata <= src_a_reg;
               end
               `OFS_SRC_B: begin
                  prdata <= src_b_reg;
               end
               `OFS_IMM: begin
                  prdata <= imm_reg;
               end
               `OFS_SHAMT: begin
                  prdata <= shamt_reg;
               end
               `OFS_CTRL: begin
                  prdata <= ctrl_reg;
               end
               `OFS_RESULT: begin
                  prdata <= alu_result;
               end
               `OFS_FLAGS: begin
                  prdata <= {28'h000_0000, flags_nzcv};
               end
               `OFS_BRANCH: begin
                  prdata <= branch_addr;
               end
               default: begin
                  prdata <= `RST_WORD;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// ### verif/alu_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module alu_monitor #(
   parameter AW = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] alu_result,
   input wire logic [3:0] flags_nzcv,
   input wire logic branch_valid,
   input wire logic [31:0] branch_addr
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire go = psel && penable && pready && pwrite;
   wire op_go = go && paddr == 8'h10;
   wire fl_go = go && paddr == 8'h18;
   wire [3:0] op = pwdata[3:0];
   property p_flags_hold;
      !(op_go && pwdata[4]) && !fl_go |=> $stable(flags_nzcv);
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("flags moved");
   property p_v_kept;
      op_go && pwdata[4] && op >= 4'h5 |=> $stable(flags_nzcv[0]);
   endproperty
   a_v_kept: assert property (p_v_kept) else $error("v flag moved");
   property p_nz;
      op_go && pwdata[4] && !pwdata[8] && op != 4'hF |=>
         flags_nzcv[3:2] == {alu_result[31], alu_result == 32'h0};
   endproperty
   a_nz: assert property (p_nz) else $error("n or z wrong");
   property p_clz_flags;
      op_go && op == 4'hF |=> $stable(flags_nzcv);
   endproperty
   a_clz_flags: assert property (p_clz_flags) else $error("clz flags");
   property p_clz_range;
      op_go && op == 4'hF |=> alu_result <= 32'h0000_0020;
   endproperty
   a_clz_range: assert property (p_clz_range) else $error("clz range");
   property p_res_hold;
      !op_go |=> $stable(alu_result);
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("result moved");
   property p_branch;
      op_go && pwdata[8] && op == 4'h0 |-> ##[1:2] branch_valid;
   endproperty
   a_branch: assert property (p_branch) else $error("no branch");
   property p_bit0;
      branch_valid |-> !branch_addr[0];
   endproperty
   a_bit0: assert property (p_bit0) else $error("branch bit 0 set");
   property p_pulse;
      branch_valid |=> !branch_valid;
   endproperty
   a_pulse: assert property (p_pulse) else $error("branch too long");
   cover property (op_go && pwdata[4]);
   cover property (branch_valid);
   cover property (op_go && op == 4'hF);
endmodule
bind integer_alu_shift_datapath alu_monitor #(.AW(AW)) mon_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .alu_result(alu_result),
   .flags_nzcv(flags_nzcv), .branch_valid(branch_valid),
   .branch_addr(branch_addr)
);
`default_nettype wire

// ### verif/apb_master.sv
`timescale 1ns/1ps
`default_nettype none
module apb_master (
   input wire logic pclk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   logic [31:0] rdata;
   logic err;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      int n;
      logic late;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      late = (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines show junk, not the last request
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
      if (late) begin
         tb.mismatches++;
         tb.final_report();
      end
   endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "alu_datapath_consts.vh"
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, branch_valid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, alu_result, branch_addr;
   logic [3:0] flags_nzcv;
   int mismatches = 0;
   int compares = 0;
   int branch_pulses = 0;
   always @(posedge pclk) begin
      if (branch_valid === 1'b1)
         branch_pulses++;
   end
   always #5 pclk = ~pclk;
   integer_alu_shift_datapath #(.AW(8)) dut_u (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .alu_result(alu_result), .flags_nzcv(flags_nzcv),
      .branch_valid(branch_valid), .branch_addr(branch_addr));
   apb_master mst_u (.pclk(pclk), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));
   task automatic check(input string nm, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      mst_u.xfer(1'b1, a, d);
   endtask
   task automatic rd(input string nm, input logic [7:0] a,
         input logic [31:0] e);
      mst_u.xfer(1'b0, a, 32'h0000_0000);
      check(nm, mst_u.rdata, e);
   endtask
   task automatic run(input logic [31:0] a, b, x, input logic [3:0] fi,
         input logic [11:0] c, input logic [31:0] r, input logic [3:0] fo);
      wr(`OFS_SRC_A, a);
      wr(`OFS_SRC_B, b);
      wr(`OFS_IMM, x);
      wr(`OFS_SHAMT, x);
      wr(`OFS_FLAGS, {28'h0, fi});
      wr(`OFS_CTRL, {20'h0, c});
      rd("result", `OFS_RESULT, r);
      rd("flags", `OFS_FLAGS, {28'h0, fo});
      rd("src_b", `OFS_SRC_B, b);
      rd("src_a", `OFS_SRC_A, (c[3:0] < 4'hA && !c[9]) ? r : a);
      check("alu_result", alu_result, r);
      check("flags port", {28'h0, flags_nzcv}, {28'h0, fo});
   endtask
   task automatic t_regs;
      rd("reset result", `OFS_RESULT, 32'h0000_0000);
      rd("reset flags", `OFS_FLAGS, 32'h0000_0000);
      wr(`OFS_RESULT, 32'h1234_5678);
      check("ro slverr", {31'h0, mst_u.err}, 32'h0000_0000);
      rd("ro result", `OFS_RESULT, 32'h0000_0000);
      rd("unmapped", 8'h20, 32'h0000_0000);
      check("slverr", {31'h0, mst_u.err}, 32'h0000_0001);
      $display("test regs done");
   endtask
   task automatic t_arith;
      run(32'hFFFF_FFFF, 32'h1, 32'h0, 4'h0, 12'h210, 32'h0, 4'h6);
      run(32'h1, 32'h2, 32'h0, 4'h2, 12'h211, 32'h4, 4'h0);
      run(32'h8000_0000, 32'h1, 32'h0, 4'h0, 12'h212, 32'h7FFF_FFFF, 4'h3);
      run(32'h5, 32'h2, 32'h0, 4'h0, 12'h213, 32'h2, 4'h2);
      run(32'h3, 32'h1, 32'h0, 4'h0, 12'h214, 32'hFFFF_FFFE, 4'h8);
      run(32'h1, 32'h0, 32'hFFFF_F0FF, 4'hF, 12'h020, 32'h100, 4'hF);
      $display("test arith done");
   endtask
   task automatic t_logic;
      run(32'hF0F0_F0F0, 32'hFF00_FF00, 32'h0, 4'h3, 12'h215,
          32'hF000_F000, 4'hB);
      run(32'h0F, 32'hF0, 32'h0, 4'h0, 12'h206, 32'hFF, 4'h0);
      run(32'hFF, 32'hFF, 32'h0, 4'h0, 12'h217, 32'h0, 4'h4);
      run(32'hFF, 32'h0F, 32'h0, 4'h0, 12'h208, 32'hF0, 4'h0);
      run(32'h0, 32'hFFFF_FFF0, 32'h0, 4'h0, 12'h209, 32'hF, 4'h0);
      $display("test logic done");
   endtask
   task automatic t_shift;
      run(32'h0, 32'h8000_0000, 32'h4, 4'h0, 12'h21A, 32'hF800_0000, 4'h8);
      run(32'h0, 32'h8000_0001, 32'h101, 4'h0, 12'h25B, 32'h2, 4'h2);
      run(32'h0, 32'h8000_0003, 32'h20, 4'h0, 12'h21C, 32'h0, 4'h6);
      run(32'h0, 32'h3, 32'h0, 4'h2, 12'h21C, 32'h3, 4'h2);
      run(32'h0, 32'h1, 32'h1, 4'h0, 12'h21D, 32'h8000_0000, 4'hA);
      run(32'h0, 32'h3, 32'h0, 4'h2, 12'h21E, 32'h8000_0001, 4'hA);
      run(32'h0, 32'h0, 32'h0, 4'h5, 12'h21F, 32'h20, 4'h5);
      $display("test shift done");
   endtask
   task automatic t_branch;
      // pc base sum and difference keep the suffix off; the difference uses a small constant
      run(32'h1003, 32'h11, 32'h0, 4'h0, 12'h380, 32'h1011, 4'h0);
      rd("branch", `OFS_BRANCH, 32'h1010);
      check("branch port", branch_addr, 32'h0000_1010);
      check("branch pulses", branch_pulses, 32'h0000_0001);
      run(32'h1003, 32'h0, 32'h4, 4'h0, 12'h2A2, 32'h0FFC, 4'h0);
      check("branch held", branch_addr, 32'h0000_1010);
      check("no branch", branch_pulses, 32'h0000_0001);
      $display("test branch done");
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_arith();
      t_logic();
      t_shift();
      t_branch();
      final_report();
   end
endmodule
`default_nettype wire
